// ### bta_bus_model.sv
// Model of the emulated processor bus feeding the trace block
`timescale 1ns/1ps
`default_nettype none
module bta_bus (
	// Clock and pacing
	input wire logic clk,
	input wire logic en, // Issue bus cycles
	input wire logic slow, // Random idle gaps
	// Observed bus cycle
	output logic valid,
	output logic write,
	output logic [2:0] typ,
	output logic [23:0] addr,
	output logic [15:0] data,
	output logic [31:0] aux
);
	logic [79:0] rnd = 80'h0; // Fields change every clock, idle too
	logic v_q = 1'b0; // One cycle per clock at most
	// Fresh fields each clock so no stale value is mistaken for data
	always @(posedge clk)
	begin
		rnd <= 80'({$urandom, $urandom, $urandom});
		v_q <= en && (!slow || rnd[79]);
	end
	assign valid = v_q;
	assign {write, typ, addr, data, aux} = rnd[75:0];
endmodule
`default_nettype wire

// ### bta_map.svh
// Register offsets, field positions and timing counts of the trace block
// Summary of operation
// - Full buffer overwrites oldest record
// - Suppressed bus cycle types are not stored
// - Tick selectable: off, 125ns up to 100us
// - 32-bit stamp advances per tick while active
// - Stamp counter wraps to zero, capture continues
// - Disabled stamp stores no stamp value
// - Stamp replaces auxiliary fields in record
// - Continuous mode: start at run, ignore channels
// - Otherwise channels decide start and stop of storing
// - Missing event point disables its function
// - Immediate and delayed stop independent, concurrent
// - Immediate stop halts on the hit cycle
// - Delayed stop stores 0..65535 more cycles
// - Channel mode: off, window, range, event
// - Window mode: start and stop addresses
// - Cyclic option re-arms start after stop
// - Range mode stores only matching cycles
// - Event mode: start event, stop event
// - No condition: capture all until halt
// - Buffer holds 32768 records
// - Delayed stop hit record is index zero; the TRIG register holds its buffer index instead
// - Stamp counter clears at each run start
`ifndef BTA_MAP_SVH
`define BTA_MAP_SVH
`define BTA_R_CTRL 8'h00
`define BTA_R_SUPP 8'h04
`define BTA_R_ISEL 8'h08
`define BTA_R_DSEL 8'h0c
`define BTA_R_DELAY 8'h10
`define BTA_R_STAT 8'h14
`define BTA_R_WPTR 8'h18
`define BTA_R_TSV 8'h1c
`define BTA_R_RIDX 8'h20
`define BTA_R_REC0 8'h24
`define BTA_R_REC1 8'h28
`define BTA_R_REC2 8'h2c
`define BTA_R_TRIG 8'h30
`define BTA_R_CHCFG 8'h40
`define BTA_R_CHSTA 8'h60
`define BTA_R_CHSTP 8'h80
`define BTA_CH_STRIDE 4
`define BTA_CTRL_CONT 0
`define BTA_CTRL_TS_LO 1
`define BTA_CTRL_ISTOP 5
`define BTA_CTRL_DSTOP 6
`define BTA_CFG_CYCLIC 2
`define BTA_CLK_MHZ 200
`define BTA_CYC(ns) ((ns) * `BTA_CLK_MHZ / 1000)
`define BTA_TS_125NS 125
`define BTA_TS_250NS 250
`define BTA_TS_500NS 500
`define BTA_TS_1US 1000
`define BTA_TS_2US 2000
`define BTA_TS_4US 4000
`define BTA_TS_8US 8000
`define BTA_TS_16US 16000
`define BTA_TS_100US 100000
`define BTA_DEPTH 32768
`endif

// ### bta_pkg.sv
// Types shared by the trace acquisition block
`default_nettype none
package bta_pkg;
	// Range channel modes
	typedef enum logic [1:0]
	{
		BTA_OFF = 2'b00,
		BTA_ADDRESS_WINDOW_MODE = 2'b01,
		BTA_RANGE = 2'b10,
		BTA_EVENT = 2'b11
	} bta_mode_t;
	// Stamp resolution selector codes
	typedef enum logic [3:0]
	{
		BTA_TS_OFF = 4'h0,
		BTA_TS_125N = 4'h1,
		BTA_TS_250N = 4'h2,
		BTA_TS_500N = 4'h3,
		BTA_TS_1U = 4'h4,
		BTA_TS_2U = 4'h5,
		BTA_TS_4U = 4'h6,
		BTA_TS_8U = 4'h7,
		BTA_TS_16U = 4'h8,
		BTA_TS_100U = 4'h9
	} bta_ts_t;
endpackage
`default_nettype wire

// ### bta_trace.sv
// Bus trace acquisition controller with circular record buffer
//
// Our own choices: the register addresses and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
`include "bta_map.svh"
module bta_trace #(
	// 100 us tick in clocks; shorten in simulation
	parameter logic [14:0] TS_100US_CYC = 15'(`BTA_CYC(`BTA_TS_100US))
) (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RESET,
	// Run control of the emulated program
	input wire logic RUN_START,
	input wire logic RUN_ACTIVE,
	// Observed bus cycle
	input wire logic BUS_VALID,
	input wire logic [23:0] BUS_ADDR,
	input wire logic [15:0] BUS_DATA,
	input wire logic BUS_WRITE,
	input wire logic [2:0] BUS_TYPE,
	input wire logic [31:0] BUS_AUX,
	// Event point matches and presence
	input wire logic [7:0] EVT_HIT,
	input wire logic [7:0] EVT_LIVE,
	// Register port
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	output logic [31:0] REG_RDATA,
	// Capture state
	output logic TRACE_ACTIVE
);
	import bta_pkg::*;

	localparam int NCH = 4;

	// Configuration
	logic [6:0] ctrl_q;
	logic [7:0] supp_q;
	logic [7:0] isel_q;
	logic [7:0] dsel_q;
	logic [15:0] delay_q;
	logic [8:0] cfg_q [NCH];
	logic [23:0] sta_q [NCH];
	logic [23:0] stp_q [NCH];
	logic [14:0] ridx_q;
	// Capture state
	logic [14:0] wptr_q;
	logic wrap_q;
	logic halt_q;
	logic dly_q;
	logic [15:0] dcnt_q;
	logic [14:0] trig_q;
	logic [31:0] ts_q;
	logic [14:0] pre_q;
	logic [31:0] rdata_q;
	logic act_q;
	// Record memory
	logic [72:0] mem [`BTA_DEPTH];
	// Per channel gating
	logic [NCH-1:0] win_q;
	logic [NCH-1:0] done_q;
	logic [NCH-1:0] ch_used;
	logic [NCH-1:0] ch_pass;
	// Channel register readback, one slice per channel, ORed together
	logic [31:0] ch_rd [NCH];
	logic [31:0] ch_rd_any;

	// Decoded controls
	logic cont;
	bta_ts_t ts_sel;
	logic [14:0] tick_per;
	logic ts_on;
	logic istop_hit;
	logic dstop_hit;
	logic gate;
	logic store;
	logic tick;

	assign cont = ctrl_q[`BTA_CTRL_CONT];
	assign ts_sel = bta_ts_t'(ctrl_q[`BTA_CTRL_TS_LO +: 4]);
	assign ts_on = (ts_sel != BTA_TS_OFF);

	// Only selected events that still exist can stop; both stops coexist
	assign istop_hit = ctrl_q[`BTA_CTRL_ISTOP] &&
		|(isel_q & EVT_LIVE & EVT_HIT);
	assign dstop_hit = ctrl_q[`BTA_CTRL_DSTOP] && !dly_q &&
		|(dsel_q & EVT_LIVE & EVT_HIT);

	// Channel logic, one copy per range channel
	genvar g;
	generate
		for (g = 0; g < NCH; g++)
		begin : g_ch
			bta_mode_t md;
			logic [2:0] sev;
			logic [2:0] pev;
			logic go;
			logic end_;
			assign md = bta_mode_t'(cfg_q[g][1:0]);
			assign sev = cfg_q[g][5:3];
			assign pev = cfg_q[g][8:6];
			// Start and stop triggers by mode
			always_comb
			begin
				go = 1'b0;
				end_ = 1'b0;
				ch_used[g] = 1'b0;
				ch_pass[g] = 1'b0;
				unique case (md)
					BTA_OFF:
					begin
						ch_used[g] = 1'b0;
					end
					BTA_ADDRESS_WINDOW_MODE:
					begin
						// Single address access opens and closes it
						go = BUS_VALID && BUS_ADDR == sta_q[g];
						end_ = BUS_VALID && BUS_ADDR == stp_q[g];
						ch_used[g] = 1'b1;
						ch_pass[g] = win_q[g] || (go && !done_q[g]);
					end
					BTA_RANGE:
					begin
						// Consumes the start event slot only
						ch_used[g] = EVT_LIVE[sev];
						ch_pass[g] = EVT_LIVE[sev] && EVT_HIT[sev];
					end
					BTA_EVENT:
					begin
						go = EVT_LIVE[sev] && EVT_HIT[sev];
						end_ = EVT_LIVE[pev] && EVT_HIT[pev];
						ch_used[g] = EVT_LIVE[sev] && EVT_LIVE[pev];
						ch_pass[g] = ch_used[g] &&
							(win_q[g] || (go && !done_q[g]));
					end
				endcase
			end
			// Window state; cyclic clears the one-shot latch
			always_ff @(posedge CLOCK or posedge RESET)
			begin
				if (RESET)
				begin
					win_q[g] <= 1'b0;
					done_q[g] <= 1'b0;
				end
				else if (RUN_START || md == BTA_OFF || md == BTA_RANGE)
				begin
					win_q[g] <= 1'b0;
					done_q[g] <= 1'b0;
				end
				else if (end_ && (win_q[g] || go))
				begin
					// Stop cycle itself is still inside the window
					win_q[g] <= 1'b0;
					done_q[g] <= !cfg_q[g][`BTA_CFG_CYCLIC];
				end
				else if (go && !done_q[g])
				begin
					win_q[g] <= 1'b1;
				end
			end
			// Channel configuration writes
			always_ff @(posedge CLOCK or posedge RESET)
			begin
				if (RESET)
				begin
					cfg_q[g] <= 9'h000;
					sta_q[g] <= 24'h000000;
					stp_q[g] <= 24'h000000;
				end
				else if (REG_WR)
				begin
					if (REG_ADDR == 8'(`BTA_R_CHCFG + `BTA_CH_STRIDE * g))
						cfg_q[g] <= REG_WDATA[8:0];
					if (REG_ADDR == 8'(`BTA_R_CHSTA + `BTA_CH_STRIDE * g))
						sta_q[g] <= REG_WDATA[23:0];
					if (REG_ADDR == 8'(`BTA_R_CHSTP + `BTA_CH_STRIDE * g))
						stp_q[g] <= REG_WDATA[23:0];
				end
			end
			// Readback of this channel; zero when another offset is chosen
			assign ch_rd[g] =
				(REG_ADDR == 8'(`BTA_R_CHCFG + `BTA_CH_STRIDE * g)) ?
				{23'h000000, cfg_q[g]} :
				(REG_ADDR == 8'(`BTA_R_CHSTA + `BTA_CH_STRIDE * g)) ?
				{8'h00, sta_q[g]} :
				(REG_ADDR == 8'(`BTA_R_CHSTP + `BTA_CH_STRIDE * g)) ?
				{8'h00, stp_q[g]} : 32'h00000000;
		end
	endgenerate

	// Only one channel slice can match an address, so OR is safe
	assign ch_rd_any = ch_rd[0] | ch_rd[1] | ch_rd[2] | ch_rd[3];

	// Continuous mode ignores channels; no channel set means take all
	assign gate = cont || ch_used == '0 || |(ch_pass & ch_used);
	// The immediate stop hit cycle itself is not kept
	assign store = BUS_VALID && RUN_ACTIVE && !halt_q && !istop_hit &&
		gate && !supp_q[BUS_TYPE];

	// Configuration register writes
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			ctrl_q <= 7'h00;
			supp_q <= 8'h00;
			isel_q <= 8'h00;
			dsel_q <= 8'h00;
			delay_q <= 16'h0001;
			ridx_q <= 15'h0000;
		end
		else if (REG_WR)
		begin
			unique case (REG_ADDR)
				`BTA_R_CTRL: ctrl_q <= REG_WDATA[6:0];
				`BTA_R_SUPP: supp_q <= REG_WDATA[7:0];
				`BTA_R_ISEL: isel_q <= REG_WDATA[7:0];
				`BTA_R_DSEL: dsel_q <= REG_WDATA[7:0];
				`BTA_R_DELAY: delay_q <= REG_WDATA[15:0];
				`BTA_R_RIDX: ridx_q <= REG_WDATA[14:0];
				default:
				begin
					// Other offsets are channel registers (written per channel), read only or unmapped
				end
			endcase
		end
	end

	// Tick period in clocks for the chosen resolution
	always_comb
	begin
		unique case (ts_sel)
			BTA_TS_125N: tick_per = 15'(`BTA_CYC(`BTA_TS_125NS));
			BTA_TS_250N: tick_per = 15'(`BTA_CYC(`BTA_TS_250NS));
			BTA_TS_500N: tick_per = 15'(`BTA_CYC(`BTA_TS_500NS));
			BTA_TS_1U: tick_per = 15'(`BTA_CYC(`BTA_TS_1US));
			BTA_TS_2U: tick_per = 15'(`BTA_CYC(`BTA_TS_2US));
			BTA_TS_4U: tick_per = 15'(`BTA_CYC(`BTA_TS_4US));
			BTA_TS_8U: tick_per = 15'(`BTA_CYC(`BTA_TS_8US));
			BTA_TS_16U: tick_per = 15'(`BTA_CYC(`BTA_TS_16US));
			BTA_TS_100U: tick_per = TS_100US_CYC;
			default: tick_per = 15'h0000;
		endcase
	end

	assign tick = ts_on && tick_per != 15'h0000 &&
		pre_q == tick_per - 15'h0001;

	// Stamp prescaler and 32-bit counter, both cleared at run start
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			pre_q <= 15'h0000;
			ts_q <= 32'h00000000;
		end
		else if (RUN_START)
		begin
			pre_q <= 15'h0000;
			ts_q <= 32'h00000000;
		end
		else if (act_q && ts_on)
		begin
			pre_q <= tick ? 15'h0000 : pre_q + 15'h0001;
			// Natural wrap returns to zero without pausing capture
			if (tick)
				ts_q <= ts_q + 32'h00000001;
		end
	end

	// Record write; stamp takes the auxiliary field slot when enabled
	always_ff @(posedge CLOCK)
	begin
		if (store)
			mem[wptr_q] <= {BUS_WRITE, BUS_ADDR, BUS_DATA,
				ts_on ? ts_q : BUS_AUX};
	end

	// Write pointer, wrap flag and stop sequencing
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
		begin
			wptr_q <= 15'h0000;
			wrap_q <= 1'b0;
			halt_q <= 1'b0;
			dly_q <= 1'b0;
			dcnt_q <= 16'h0000;
			trig_q <= 15'h0000;
		end
		else if (RUN_START)
		begin
			// Each run keeps only its own records
			wptr_q <= 15'h0000;
			wrap_q <= 1'b0;
			halt_q <= 1'b0;
			dly_q <= 1'b0;
			dcnt_q <= 16'h0000;
		end
		else
		begin
			if (store)
			begin
				// Pointer simply rolls over the oldest entry
				wptr_q <= wptr_q + 15'h0001;
				if (wptr_q == 15'h7fff)
					wrap_q <= 1'b1;
			end
			if (istop_hit)
				halt_q <= 1'b1;
			else if (dstop_hit && BUS_VALID && !halt_q)
			begin
				// Hit record index is saved in trig_q; count runs after it
				trig_q <= wptr_q;
				dly_q <= 1'b1;
				dcnt_q <= delay_q;
				if (delay_q == 16'h0000)
					halt_q <= 1'b1;
			end
			else if (dly_q && BUS_VALID && !halt_q)
			begin
				dcnt_q <= dcnt_q - 16'h0001;
				if (dcnt_q == 16'h0001)
					halt_q <= 1'b1;
			end
		end
	end

	// Acquisition active flag: running and not halted
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
			act_q <= 1'b0;
		else
			act_q <= RUN_ACTIVE && !(halt_q || istop_hit) && !RUN_START
				|| RUN_START;
	end

	assign TRACE_ACTIVE = act_q;

	// Read data, valid only in the cycle after the strobe
	always_ff @(posedge CLOCK or posedge RESET)
	begin
		if (RESET)
			rdata_q <= 32'h00000000;
		else if (!REG_RD)
			rdata_q <= 32'h00000000;
		else
		begin
			unique case (REG_ADDR)
				`BTA_R_CTRL: rdata_q <= {25'h0000000, ctrl_q};
				`BTA_R_SUPP: rdata_q <= {24'h000000, supp_q};
				`BTA_R_ISEL: rdata_q <= {24'h000000, isel_q};
				`BTA_R_DSEL: rdata_q <= {24'h000000, dsel_q};
				`BTA_R_DELAY: rdata_q <= {16'h0000, delay_q};
				`BTA_R_STAT: rdata_q <= {8'h00, dcnt_q, win_q,
					dly_q, wrap_q, halt_q, act_q};
				`BTA_R_WPTR: rdata_q <= {17'h00000, wptr_q};
				`BTA_R_TSV: rdata_q <= ts_q;
				`BTA_R_RIDX: rdata_q <= {17'h00000, ridx_q};
				`BTA_R_REC0: rdata_q <= {7'h00, mem[ridx_q][72:48]};
				`BTA_R_REC1: rdata_q <= {16'h0000, mem[ridx_q][47:32]};
				`BTA_R_REC2: rdata_q <= mem[ridx_q][31:0];
				`BTA_R_TRIG: rdata_q <= {17'h00000, trig_q};
				// Channel registers or unmapped (zero)
				default: rdata_q <= ch_rd_any;
			endcase
		end
	end

	assign REG_RDATA = rdata_q;
endmodule
`default_nettype wire

// ### bta_trace_assertions.sv
// Port checker for the trace block, bound to its top module
`timescale 1ns/1ps
`default_nettype none
module bta_chk (
	// Clock and reset
	input wire logic CLOCK,
	input wire logic RESET,
	// Run control and events
	input wire logic RUN_START,
	input wire logic RUN_ACTIVE,
	input wire logic [7:0] EVT_HIT,
	// Register port and capture state
	input wire logic [7:0] REG_ADDR,
	input wire logic [31:0] REG_WDATA,
	input wire logic REG_WR,
	input wire logic REG_RD,
	input wire logic [31:0] REG_RDATA,
	input wire logic TRACE_ACTIVE
);
	default clocking @(posedge CLOCK); endclocking
	default disable iff (RESET);
	logic [6:0] ctl_q; // Control shadow
	logic [7:0] sup_q; // Suppress mask shadow
	logic [15:0] dly_q; // Delay shadow, resets to one
	// Shadows track writes so readback is judged without the body
	always_ff @(posedge CLOCK or posedge RESET)
		if (RESET)
		begin
			ctl_q <= 7'h00;
			sup_q <= 8'h00;
			dly_q <= 16'h0001;
		end
		else if (REG_WR)
		begin
			if (REG_ADDR == 8'h00)
				ctl_q <= REG_WDATA[6:0];
			if (REG_ADDR == 8'h04)
				sup_q <= REG_WDATA[7:0];
			if (REG_ADDR == 8'h10)
				dly_q <= REG_WDATA[15:0];
		end
	property p_idle;
		!$past(REG_RD) |-> REG_RDATA == 32'h0;
	endproperty
	a_idle: assert property (p_idle) else $error("idle data");
	property p_unmap;
		REG_RD && REG_ADDR == 8'hfc |=> REG_RDATA == 32'h0;
	endproperty
	a_unmap: assert property (p_unmap) else $error("unmapped");
	property p_ctl;
		REG_RD && REG_ADDR == 8'h00 |=> REG_RDATA == {25'h0, ctl_q};
	endproperty
	a_ctl: assert property (p_ctl) else $error("control");
	property p_sup;
		REG_RD && REG_ADDR == 8'h04 |=> REG_RDATA == {24'h0, sup_q};
	endproperty
	a_sup: assert property (p_sup) else $error("suppress");
	property p_dly;
		REG_RD && REG_ADDR == 8'h10 |=> REG_RDATA == {16'h0, dly_q};
	endproperty
	a_dly: assert property (p_dly) else $error("delay");
	property p_off;
		!RUN_ACTIVE [*2] |-> !TRACE_ACTIVE;
	endproperty
	a_off: assert property (p_off) else $error("active idle");
	// A halt holds until the next run start
	property p_rise;
		$rose(TRACE_ACTIVE) |-> $past(RUN_START) || $past(RUN_START, 2)
			|| !$past(RUN_ACTIVE) || !$past(RUN_ACTIVE, 2);
	endproperty
	a_rise: assert property (p_rise) else $error("halt left");
	property p_restart;
		RUN_START && RUN_ACTIVE && EVT_HIT == 8'h00
			##1 (RUN_ACTIVE && EVT_HIT == 8'h00) [*2] |-> TRACE_ACTIVE;
	endproperty
	a_restart: assert property (p_restart) else $error("no start");
endmodule
bind bta_trace bta_chk bta_chk_i (.CLOCK, .RESET, .RUN_START, .RUN_ACTIVE,
	.EVT_HIT, .REG_ADDR, .REG_WDATA, .REG_WR, .REG_RD, .REG_RDATA,
	.TRACE_ACTIVE);
`default_nettype wire

// ### bta_trace_bench.sv
// Self-checking bench for the trace acquisition block
`timescale 1ns/1ps
`default_nettype none
module bta_trace_bench;
	logic clock = 1'b0, reset = 1'b1, run_start = 1'b0, run_active = 1'b0;
	logic en = 1'b0, slow = 1'b0, rng = 1'b0, cnt_on = 1'b0; // Modes
	logic bvalid, bwrite, tact, wr = 1'b0, rd = 1'b0;
	logic [2:0] btype;
	logic [23:0] baddr;
	logic [15:0] bdata;
	logic [31:0] baux, rdata, d, wdata = 32'h0;
	logic [7:0] evt_hit = 8'h0, evt_live = 8'hff, raddr = 8'h0, sup = 8'h0;
	logic [72:0] f_r; // First stored record seen by the bench
	int n_mismatch = 0, cmp_count = 0, cyc = 0, nst = 0;
	int pns[10] = '{0, 125, 250, 500, 1000, 2000, 4000, 8000, 16000, 0};
	bta_bus bta_bus_i (.clk(clock), .en(en), .slow(slow), .valid(bvalid),
		.write(bwrite), .typ(btype), .addr(baddr), .data(bdata), .aux(baux));
	bta_trace #(.TS_100US_CYC(15'h28)) bta_trace_i (.CLOCK(clock),
		.RESET(reset), .RUN_START(run_start), .RUN_ACTIVE(run_active),
		.BUS_VALID(bvalid), .BUS_ADDR(baddr), .BUS_DATA(bdata),
		.BUS_WRITE(bwrite), .BUS_TYPE(btype), .BUS_AUX(baux),
		.EVT_HIT(evt_hit), .EVT_LIVE(evt_live), .REG_ADDR(raddr),
		.REG_WDATA(wdata), .REG_WR(wr), .REG_RD(rd), .REG_RDATA(rdata),
		.TRACE_ACTIVE(tact));
	initial forever #2.5 clock = ~clock;
	// Count cycles that should be stored; range mode needs event 0
	always @(posedge clock)
		if (run_start)
			nst <= 0;
		else if (cnt_on && bvalid && !sup[btype] && (!rng || evt_hit[0]))
		begin
			if (nst == 0)
				f_r <= {bwrite, baddr, bdata, baux};
			nst <= nst + 1;
		end
	// Random event hits while the range channel runs
	always @(posedge clock)
		if (rng)
			evt_hit <= 8'($urandom_range(1));
	// Hang guard
	always @(posedge clock)
	begin
		cyc <= cyc + 1;
		if (cyc == 60000)
		begin
			n_mismatch++;
			complete_run();
		end
	end
	function automatic int per(input int s);
		return (s == 9) ? 40 : pns[s] / 5;
	endfunction
	task automatic complete_run();
		$display("compares %0d mismatches %0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp)
		begin
			n_mismatch++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wreg(input logic [7:0] a, input logic [31:0] v);
		@(posedge clock);
		raddr <= a;
		wdata <= v;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask
	// Data stands only in the cycle after the strobe
	task automatic rreg(input logic [7:0] a, output logic [31:0] v);
		@(posedge clock);
		raddr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		@(negedge clock);
		v = rdata;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] v;
		rreg(a, v);
		check(v, e);
	endtask
	// Bus is quiet at the restart edge so no cycle straddles it
	task automatic go(input logic [31:0] c, input logic s);
		@(posedge clock);
		en <= 1'b0;
		cnt_on <= 1'b0;
		slow <= s;
		repeat (2) @(posedge clock);
		wreg(8'h00, c);
		@(posedge clock);
		run_start <= 1'b1;
		run_active <= 1'b1;
		@(posedge clock);
		run_start <= 1'b0;
		en <= 1'b1;
		cnt_on <= 1'b1;
	endtask
	task automatic hit(input logic [7:0] e, input logic k);
		@(posedge clock);
		evt_hit <= e;
		cnt_on <= k;
		@(posedge clock);
		evt_hit <= 8'h0;
	endtask
	initial
	begin
		void'($urandom(32'hf749));
		repeat (2) @(posedge clock);
		reset <= 1'b0;
		rchk(8'h00, 32'h0);
		rchk(8'h10, 32'h1);
		rchk(8'hfc, 32'h0);
		for (int m = 0; m < 4; m++)
		begin
			wreg(8'h44, 32'(m) | 32'h4);
			rchk(8'h44, 32'(m) | 32'h4);
		end
		wreg(8'h44, 32'h0);
		$display("defaults done");
		sup = 8'h0a;
		wreg(8'h04, 32'h0a);
		rchk(8'h04, 32'h0a);
		go(32'h1, 1'b1);
		repeat (200) @(posedge clock);
		en <= 1'b0;
		repeat (3) @(posedge clock);
		rchk(8'h18, nst);
		wreg(8'h20, 32'h0);
		rchk(8'h24, {7'h0, f_r[72:48]});
		rchk(8'h28, {16'h0, f_r[47:32]});
		rchk(8'h2c, f_r[31:0]);
		$display("suppress done");
		sup = 8'h00;
		wreg(8'h04, 32'h0);
		go(32'h1, 1'b0);
		repeat (32770) @(posedge clock);
		en <= 1'b0;
		repeat (3) @(posedge clock);
		rchk(8'h18, nst % 32768);
		rreg(8'h14, d);
		check({31'h0, d[2]}, 32'h1);
		$display("wrap done");
		wreg(8'h08, 32'h1);
		wreg(8'h0c, 32'h2);
		wreg(8'h10, 32'h3);
		evt_live <= 8'hfe;
		go(32'h61, 1'b0);
		repeat (10) @(posedge clock);
		hit(8'h1, 1'b1);
		repeat (10) @(negedge clock);
		check({31'h0, tact}, 32'h1);
		hit(8'h2, 1'b0);
		repeat (10) @(negedge clock);
		check({31'h0, tact}, 32'h0);
		rchk(8'h30, nst);
		rchk(8'h18, nst + 4);
		evt_live <= 8'hff;
		go(32'h61, 1'b0);
		repeat (5) @(posedge clock);
		hit(8'h1, 1'b0);
		repeat (4) @(negedge clock);
		check({31'h0, tact}, 32'h0);
		rchk(8'h18, nst);
		$display("stops done");
		wreg(8'h40, 32'h2);
		rng <= 1'b1;
		go(32'h0, 1'b1);
		repeat (100) @(posedge clock);
		en <= 1'b0;
		rng <= 1'b0;
		repeat (3) @(posedge clock);
		evt_hit <= 8'h0;
		rchk(8'h18, nst);
		$display("range done");
		// Event channel, cyclic: start event 2, stop event 3
		wreg(8'h40, 32'hd7);
		go(32'h0, 1'b0);
		cnt_on <= 1'b0;
		repeat (5) @(posedge clock);
		hit(8'h04, 1'b1);
		repeat (5) @(posedge clock);
		hit(8'h08, 1'b1);
		cnt_on <= 1'b0;
		repeat (5) @(posedge clock);
		rchk(8'h18, nst);
		hit(8'h04, 1'b1);
		repeat (3) @(posedge clock);
		hit(8'h08, 1'b1);
		cnt_on <= 1'b0;
		repeat (5) @(posedge clock);
		en <= 1'b0;
		rchk(8'h18, nst);
		$display("event done");
		for (int s = 1; s < 10; s++)
		begin
			go(32'(s) << 1, 1'b1);
			rchk(8'h1c, 32'h0);
			repeat (2 * per(s)) @(posedge clock);
			rreg(8'h1c, d);
			check({31'h0, d == 32'h1 || d == 32'h2}, 32'h1);
		end
		$display("stamp done");
		run_active <= 1'b0;
		repeat (3) @(negedge clock);
		check({31'h0, tact}, 32'h0);
		complete_run();
	end
endmodule
`default_nettype wire
